// [design/rti_defs.svh]
`ifndef RTI_DEFS_SVH
`define RTI_DEFS_SVH

// Register offsets on the parallel register port.
`define RTI_ADDR_W 6
`define RTI_OFS_TIMER_CLOCK 6'h2A
`define RTI_OFS_START_STOP 6'h2B
`define RTI_OFS_PRESET 6'h2C
`define RTI_OFS_PIN_CONFIG 6'h2D

// Reset values.
`define RTI_RST_TIMER_CLOCK 8'h0B
`define RTI_RST_START_STOP 8'h02
`define RTI_RST_PRESET 8'h00
`define RTI_RST_PIN_CONFIG 8'h02

// Field positions.
`define RTI_BIT_START_TX_FIRST 0
`define RTI_BIT_START_TX_END 1
`define RTI_BIT_STOP_RX_FIRST 2
`define RTI_BIT_STOP_RX_END 3
`define RTI_BIT_AUTO_RELOAD 5
`define RTI_EXP_HI 4
`define RTI_EXP_MAX 5'h0F
`define RTI_BIT_PIN_DRIVE_TYPE 0
`define RTI_BIT_PIN_INVERT 1

// Timing: core clock and timer reference in kHz, tick accumulator width.
`define RTI_CLK_KHZ 250000
`define RTI_REF_KHZ 13560
`define RTI_ACC_W 18
`define RTI_PRESC_W 16

`endif

// [design/rti_pkg.sv]
package rti_pkg;

  // Transceiver events, each a one-cycle pulse.
  typedef struct packed {
    logic tx_first_bit;
    logic tx_end;
    logic rx_first_bit;
    logic rx_end;
  } rti_events_t;

  // Register port request.
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rti_reg_req_t;

  typedef enum logic [0:0] {
    RTI_IDLE,
    RTI_RUN
  } rti_state_t;

endpackage : rti_pkg

// [design/rti_timer_ctrl.sv]
`timescale 1ns/10ps
`include "rti_defs.svh"

// Function
// - Start-on-first-transmitted-bit enabled: first sent bit starts the timer.
// - Start-on-transmit-end enabled: end of transmission starts the timer.
// - Enabled start while counting restarts by reloading the preset value.
// - Stop-on-first-received-bit enabled: first valid received bit halts the timer.
// - Stop-on-receive-end enabled: end of reception halts the timer.
// - A cleared start or stop bit makes that event ignored.
// - Start/stop control register at 2Bh, reset value 02h.
// - Every start copies the preset value register into the counter.
// - Writing the preset leaves a running count alone until next start.
// - A zero preset value prevents the timer from starting.
// - Preset value register at 2Ch, read/write, resets to 00h.
// - Invert bit set drives the pin as complement of the request bit.
// - Drive-type bit clear gives open drain, set gives push-pull.
// - Pin configuration register at 2Dh resets to 02h.
// - Auto-reload on: reload preset on the tick that would reach zero, and keep counting.
// - Auto-reload off: count to zero, stop, raise the expired flag.
// - Tick rate is 13.56 MHz over two to the divider exponent, 0 to 15.
module rti_timer_ctrl (
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Register port.
  input wire rti_pkg::rti_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Transceiver events and the internal interrupt request bit.
  input wire rti_pkg::rti_events_t events_i,
  input wire logic irq_request_i,
  // Interrupt pin.
  output logic irq_pin_o,
  output logic irq_pin_oe_o,
  // Timer status.
  output logic [7:0] timer_value_o,
  output logic timer_running_o,
  output logic timer_expired_o
);

  // Address match, shared by the write and read paths.
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  logic [7:0] clock_cfg_q, clock_cfg_d;
  logic [7:0] start_stop_q, start_stop_d;
  logic [7:0] preset_q, preset_d;
  logic [7:0] pin_cfg_q, pin_cfg_d;
  logic [7:0] rdata_q, rdata_d;

  // Register writes and registered read data.
  always_comb begin
    clock_cfg_d = clock_cfg_q;
    start_stop_d = start_stop_q;
    preset_d = preset_q;
    pin_cfg_d = pin_cfg_q;
    rdata_d = rdata_q;
    if (reg_req_i.wr) begin
      if (hit(reg_req_i.addr, `RTI_OFS_TIMER_CLOCK)) clock_cfg_d = reg_req_i.wdata;
      if (hit(reg_req_i.addr, `RTI_OFS_START_STOP)) start_stop_d = reg_req_i.wdata;
      if (hit(reg_req_i.addr, `RTI_OFS_PRESET)) preset_d = reg_req_i.wdata;
      if (hit(reg_req_i.addr, `RTI_OFS_PIN_CONFIG)) pin_cfg_d = reg_req_i.wdata;
    end
    if (reg_req_i.rd) begin
      if (hit(reg_req_i.addr, `RTI_OFS_TIMER_CLOCK)) rdata_d = clock_cfg_q;
      else if (hit(reg_req_i.addr, `RTI_OFS_START_STOP)) rdata_d = start_stop_q;
      else if (hit(reg_req_i.addr, `RTI_OFS_PRESET)) rdata_d = preset_q;
      else if (hit(reg_req_i.addr, `RTI_OFS_PIN_CONFIG)) rdata_d = pin_cfg_q;
      else rdata_d = 8'h00;
    end
  end

  // Register storage.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clock_cfg_q <= `RTI_RST_TIMER_CLOCK;
      start_stop_q <= `RTI_RST_START_STOP;
      preset_q <= `RTI_RST_PRESET;
      pin_cfg_q <= `RTI_RST_PIN_CONFIG;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      clock_cfg_q <= clock_cfg_d;
      start_stop_q <= start_stop_d;
      preset_q <= preset_d;
      pin_cfg_q <= pin_cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // 13.56 MHz reference by fractional accumulation, then the power-of-two divider.
  // The reference has up to one core cycle of jitter; the average rate is exact.
  logic [`RTI_ACC_W-1:0] acc_q, acc_d;
  logic [`RTI_PRESC_W-1:0] presc_q, presc_d;
  logic [4:0] exp_eff;
  logic ref_tick;
  logic timer_tick;
  logic [`RTI_ACC_W:0] acc_sum;

  always_comb begin
    // Exponents above 15 are clamped, since only 0 to 15 are defined.
    exp_eff = clock_cfg_q[`RTI_EXP_HI:0];
    if (exp_eff > `RTI_EXP_MAX) exp_eff = `RTI_EXP_MAX;
    acc_sum = {1'b0, acc_q} + (`RTI_ACC_W+1)'(`RTI_REF_KHZ);
    ref_tick = (acc_sum >= (`RTI_ACC_W+1)'(`RTI_CLK_KHZ));
    acc_d = ref_tick ? `RTI_ACC_W'(acc_sum - (`RTI_ACC_W+1)'(`RTI_CLK_KHZ)) : acc_sum[`RTI_ACC_W-1:0];
    presc_d = presc_q;
    timer_tick = 1'b0;
    if (ref_tick) begin
      if (presc_q >= ((`RTI_PRESC_W'(1) << exp_eff) - `RTI_PRESC_W'(1))) begin
        presc_d = '0;
        timer_tick = 1'b1;
      end else begin
        presc_d = presc_q + `RTI_PRESC_W'(1);
      end
    end
  end

  // Tick generator state.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= '0;
      presc_q <= '0;
    end else if (ce_i) begin
      acc_q <= acc_d;
      presc_q <= presc_d;
    end
  end

  // Start and stop conditions, each gated by its own enable bit.
  logic start_ev, stop_ev;
  assign start_ev = (events_i.tx_first_bit & start_stop_q[`RTI_BIT_START_TX_FIRST])
                  | (events_i.tx_end & start_stop_q[`RTI_BIT_START_TX_END]);
  assign stop_ev = (events_i.rx_first_bit & start_stop_q[`RTI_BIT_STOP_RX_FIRST])
                 | (events_i.rx_end & start_stop_q[`RTI_BIT_STOP_RX_END]);

  rti_pkg::rti_state_t state_q, state_d;
  logic [7:0] count_q, count_d;
  logic expired_q, expired_d;

  // Timer sequencing. A start wins over a stop in the same cycle, so a
  // restart is never lost; expiry is flagged even when a stop coincides.
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    expired_d = 1'b0;
    case (state_q)
      rti_pkg::RTI_IDLE: begin
        if (start_ev && preset_q != 8'h00) begin
          state_d = rti_pkg::RTI_RUN;
          count_d = preset_q;
        end
      end
      rti_pkg::RTI_RUN: begin
        if (start_ev && preset_q != 8'h00) begin
          count_d = preset_q;
        end else begin
          if (timer_tick) begin
            if (count_q <= 8'h01) begin
              if (clock_cfg_q[`RTI_BIT_AUTO_RELOAD] && preset_q != 8'h00) begin
                count_d = preset_q;
              end else begin
                count_d = 8'h00;
                state_d = rti_pkg::RTI_IDLE;
                expired_d = 1'b1;
              end
            end else begin
              count_d = count_q - 8'h01;
            end
          end
          if (stop_ev) begin
            state_d = rti_pkg::RTI_IDLE;
            if (!expired_d) count_d = count_q;
          end
        end
      end
      default: begin
        state_d = rti_pkg::RTI_IDLE;
      end
    endcase
  end

  // Timer state.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= rti_pkg::RTI_IDLE;
      count_q <= 8'h00;
      expired_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      count_q <= count_d;
      expired_q <= expired_d;
    end else begin
      expired_q <= 1'b0;
    end
  end

  assign timer_value_o = count_q;
  assign timer_running_o = (state_q == rti_pkg::RTI_RUN);
  assign timer_expired_o = expired_q;

  // Interrupt pin stage; open drain releases the pin for a high level.
  logic pin_q, pin_d, pin_oe_q, pin_oe_d;
  logic pin_level;

  always_comb begin
    pin_level = irq_request_i ^ pin_cfg_q[`RTI_BIT_PIN_INVERT];
    if (pin_cfg_q[`RTI_BIT_PIN_DRIVE_TYPE]) begin
      pin_d = pin_level;
      pin_oe_d = 1'b1;
    end else begin
      pin_d = 1'b0;
      pin_oe_d = ~pin_level;
    end
  end

  // Pin registers.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (ce_i) begin
      pin_q <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign irq_pin_o = pin_q;
  assign irq_pin_oe_o = pin_oe_q;

  // Checks on the timer and the pin.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  logic running;
  assign running = (state_q == rti_pkg::RTI_RUN);

  property p_start_first_bit;
    ce_i && events_i.tx_first_bit && start_stop_q[0] && preset_q != 8'h00
      |=> running && count_q == $past(preset_q);
  endproperty
  a_start_first_bit: assert property (p_start_first_bit) else $error("first-bit start did not load");

  property p_start_tx_end;
    ce_i && events_i.tx_end && start_stop_q[1] && preset_q != 8'h00 |=> running && count_q == $past(preset_q);
  endproperty
  a_start_tx_end: assert property (p_start_tx_end) else $error("tx-end start did not load");

  property p_zero_preset;
    ce_i && !running && preset_q == 8'h00 |=> !running;
  endproperty
  a_zero_preset: assert property (p_zero_preset) else $error("timer started with zero preset");

  property p_stop_holds;
    ce_i && running && stop_ev && !start_ev && !timer_tick |=> !running && $stable(count_q);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stop did not halt and hold");

  property p_disabled_stop;
    ce_i && running && !start_stop_q[3] && !start_stop_q[2] && !timer_tick && !start_ev |=> running;
  endproperty
  a_disabled_stop: assert property (p_disabled_stop) else $error("disabled stop halted timer");

  property p_preset_write;
    ce_i && running && reg_req_i.wr && reg_req_i.addr == 6'h2C && !start_ev && !timer_tick
      |=> count_q == $past(count_q);
  endproperty
  a_preset_write: assert property (p_preset_write) else $error("preset write changed count");

  property p_expire;
    ce_i && running && timer_tick && count_q == 8'h01 && !clock_cfg_q[5] && !start_ev
      |=> timer_expired_o && !running && count_q == 8'h00 ##1 !timer_expired_o;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry not flagged");

  property p_reload;
    ce_i && running && timer_tick && count_q == 8'h01 && clock_cfg_q[5] && preset_q != 8'h00 && !start_ev && !stop_ev
      |=> running && !timer_expired_o && count_q == $past(preset_q);
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload failed");

  property p_decrement;
    ce_i && running && timer_tick && count_q > 8'h01 && !start_ev && !stop_ev |=> count_q == $past(count_q) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count did not step down");

  property p_pin_level;
    ce_i |=> (irq_pin_oe_o ? irq_pin_o : 1'b1) == ($past(irq_request_i) ^ $past(pin_cfg_q[1]));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

  property p_open_drain;
    ce_i && !pin_cfg_q[0] |=> !irq_pin_o && (irq_pin_oe_o == !($past(irq_request_i) ^ $past(pin_cfg_q[1])));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  c_start: cover property (ce_i && start_ev && !running && preset_q != 8'h00);
  c_restart: cover property (ce_i && start_ev && running);
  c_expire: cover property (timer_expired_o);
  c_stop: cover property (ce_i && running && stop_ev && !start_ev);

endmodule : rti_timer_ctrl

// [bench/rti_xcvr_model.sv]
`timescale 1ns/10ps
// Stand-in for the transceiver and the board around the interrupt pin.
module rti_xcvr_model (
  // Clock.
  input wire logic clk_i,
  // Event requests from the bench and the event pulses they become.
  input wire logic [3:0] fire_i,
  output rti_pkg::rti_events_t events_o,
  // Interrupt pin and the board-level line.
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic line_o
);
  // Each request is delayed one cycle and keeps its length, so a one-cycle request gives a single-cycle pulse, the only form the transceiver ever gives.
  always_ff @(posedge clk_i) begin
    events_o <= rti_pkg::rti_events_t'(fire_i);
  end
  // A released open-drain line is pulled up on the board, so it never keeps the last level.
  assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule : rti_xcvr_model

// [bench/test_reader_timer_and_irq_pin_ctrl.sv]
`timescale 1ns/10ps
module test_reader_timer_and_irq_pin_ctrl;
  // Register table row: write flag, address, write data, expected read-back.
  typedef struct packed {logic wr; logic [5:0] a; logic [7:0] d; logic [7:0] e;} rti_row_t;
  localparam logic [3:0] TXF = 4'h8, TXE = 4'h4, RXF = 4'h2, RXE = 4'h1;
  localparam rti_row_t ROWS [10] = '{
    '{1'b0, 6'h2A, 8'h00, 8'h0B}, '{1'b0, 6'h2B, 8'h00, 8'h02}, '{1'b0, 6'h2C, 8'h00, 8'h00},
    '{1'b0, 6'h2D, 8'h00, 8'h02}, '{1'b0, 6'h30, 8'h00, 8'h00}, '{1'b1, 6'h2B, 8'h0F, 8'h0F},
    '{1'b1, 6'h2C, 8'hA5, 8'hA5}, '{1'b1, 6'h2D, 8'h01, 8'h01}, '{1'b1, 6'h30, 8'h5A, 8'h00},
    '{1'b1, 6'h2A, 8'h00, 8'h00}};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic irq_req = 1'b0;
  logic [3:0] fire = 4'h0;
  rti_pkg::rti_reg_req_t req = '0;
  rti_pkg::rti_events_t evts;
  logic [7:0] rdata, tval, v;
  logic pin, oe, line, trun, texp, lvl;
  int n_mismatch = 0;
  int check_count = 0;

  // Free-running 250 MHz clock.
  always #2 clk_i = ~clk_i;

  rti_timer_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .events_i(evts), .irq_request_i(irq_req), .irq_pin_o(pin),
    .irq_pin_oe_o(oe), .timer_value_o(tval), .timer_running_o(trun), .timer_expired_o(texp));
  rti_xcvr_model u_xcvr (.clk_i(clk_i), .fire_i(fire), .events_o(evts), .pin_i(pin),
    .pin_oe_i(oe), .line_o(line));

  // Compare tasks, one per result width.
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t bit got %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Register port: a strobe stands for one cycle and is taken at the next edge.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] r);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 r = rdata;
  endtask : rd
  // Fires event pulses; returns once the timer has had its cycle to react.
  task automatic ev(input logic [3:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 4'h0;
    @(posedge clk_i);
    #1;
  endtask : ev
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc

  // Hang guard, well beyond the roughly 1100 cycles the sequence needs.
  initial begin
    #40000;
    n_mismatch++;
    summarize();
  end

  // Main sequence: register table, pin table, then the timer's awkward cases.
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      chk8(v, ROWS[i].e);
    end
    for (int c = 0; c < 4; c++) begin
      wr(6'h2D, 8'(c));
      for (int r = 0; r < 2; r++) begin
        @(posedge clk_i);
        irq_req <= r[0];
        wait_cyc(2);
        lvl = r[0] ^ c[1];
        chk1(line, lvl);
        chk1(oe, c[0] | ~lvl);
        chk1(pin, c[0] ? lvl : 1'b0);
      end
    end
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(6'h2C, 8'h77);
    ce_i <= 1'b1;
    rd(6'h2C, v);
    chk8(v, 8'hA5);
    wr(6'h2C, 8'h00);
    wr(6'h2B, 8'h0F);
    ev(TXE);
    chk1(trun, 1'b0);
    wr(6'h2C, 8'h05);
    ev(TXF);
    chk8(tval, 8'h05);
    wr(6'h2C, 8'h09);
    #1;
    chk1(tval <= 8'h05 && trun, 1'b1);
    ev(TXE);
    chk8(tval, 8'h09);
    ev(RXF | TXF);
    chk1(trun, 1'b1);
    ev(RXF);
    v = tval;
    chk1(trun, 1'b0);
    wait_cyc(60);
    chk8(tval, v);
    ev(RXE);
    chk8(tval, v);
    ev(TXF);
    ev(RXE);
    chk1(trun, 1'b0);
    wr(6'h2B, 8'h00);
    ev(TXF | TXE);
    chk1(trun, 1'b0);
    wr(6'h2B, 8'h02);
    wr(6'h2C, 8'hC8);
    ev(TXE);
    ev(RXF | RXE);
    chk1(trun, 1'b1);
    ev(TXE);
    wait_cyc(368);
    chk1(tval >= 8'hB3 && tval <= 8'hB5, 1'b1);
    // Exponent one halves the tick rate; the divider phase leaves one tick of slack.
    wr(6'h2A, 8'h01);
    ev(TXE);
    wait_cyc(368);
    chk1(tval >= 8'hBD && tval <= 8'hBF, 1'b1);
    wr(6'h2C, 8'h02);
    ev(TXE);
    for (int i = 0; i < 300 && texp !== 1'b1; i++) wait_cyc(1);
    chk1(texp, 1'b1);
    #1;
    chk8(tval, 8'h00);
    chk1(trun, 1'b0);
    wr(6'h2A, 8'h20);
    wr(6'h2C, 8'h03);
    ev(TXE);
    for (int i = 0; i < 300 && tval !== 8'h01; i++) wait_cyc(1);
    for (int i = 0; i < 300 && tval === 8'h01; i++) wait_cyc(1);
    chk8(tval, 8'h03);
    chk1(trun, 1'b1);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    wait_cyc(3);
    chk1(trun, 1'b0);
    chk8(tval, 8'h00);
    chk1(oe, 1'b0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(6'h2B, v);
    chk8(v, 8'h02);
    rd(6'h2C, v);
    chk8(v, 8'h00);
    rd(6'h2D, v);
    chk8(v, 8'h02);
    summarize();
  end
endmodule : test_reader_timer_and_irq_pin_ctrl
